//--- hw/egp_consts.vh
// Purpose: Constants for the eight-bit port block
// Assumes: Word register offsets as printed, 16-bit data
// Notes:   Included by all design files
`ifndef EGP_CONSTS_VH
`define EGP_CONSTS_VH

`define EGP_OFS_FUNC     6'h00
`define EGP_OFS_OE       6'h04
`define EGP_OFS_PULL     6'h08
`define EGP_OFS_INEN     6'h0c
`define EGP_OFS_IN       6'h10
`define EGP_OFS_OUT      6'h14
`define EGP_OFS_SET      6'h18
`define EGP_OFS_CLR      6'h1c
`define EGP_OFS_TGL      6'h20
`define EGP_OFS_EVCFG0   6'h24
`define EGP_OFS_EVCFG1   6'h28
`define EGP_OFS_EVCLR    6'h2c
`define EGP_OFS_EVPEND   6'h30
`define EGP_OFS_SYNC     6'h34

`define EGP_RST_16       16'h0000
`define EGP_RST_8        8'h00
`define EGP_PULL_MASK    8'hfb

`define EGP_FN_GPIO      2'h0
`define EGP_FN_INT       2'h1
`define EGP_FN_SYNC      2'h2

`define EGP_EV_RISE      3'h0
`define EGP_EV_FALL      3'h1
`define EGP_EV_BOTH      3'h2
`define EGP_EV_HIGH      3'h3
`define EGP_EV_LOW       3'h4

`endif

//--- hw/egp_event_det.v
// Purpose: Event detector for one synchronised pin level
// Assumes: Input already passed two flip-flops
// Notes:   Edges give a pulse, levels follow the source
`timescale 1ns/100ps
`include "egp_consts.vh"

module egp_event_det (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       level_in,
  input  wire       enable,
  input  wire [2:0] mode,
  output reg        event_out
);

  reg prev_reg;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_in;
    end
  end

  always @* begin
    event_out = 1'b0;
    if (enable) begin
      case (mode)
        `EGP_EV_RISE: event_out = level_in & ~prev_reg;
        `EGP_EV_FALL: event_out = ~level_in & prev_reg;
        `EGP_EV_BOTH: event_out = level_in ^ prev_reg;
        `EGP_EV_HIGH: event_out = level_in;
        `EGP_EV_LOW:  event_out = ~level_in;
        default:      event_out = 1'b0;
      endcase
    end
  end

endmodule

//--- hw/egp_port.v
// Purpose: Eight-bit general purpose port with function multiplexer
// Assumes: Simple synchronous register port, one access per cycle
// Notes:   Pin pads resolve level from pin_out and pin_oe
`timescale 1ns/100ps
`include "egp_consts.vh"

module egp_port #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire [5:0]       reg_addr,
  input  wire             reg_wr,
  input  wire             reg_rd,
  input  wire [15:0]      reg_wdata,
  output reg  [15:0]      reg_rdata,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out,
  output wire [WIDTH-1:0] pin_oe,
  output wire [WIDTH-1:0] pull_up_on,
  input  wire             interrupt_line_zero,
  input  wire             interrupt_line_one,
  input  wire             seq_sync_wr,
  input  wire [WIDTH-1:0] seq_sync_data,
  output wire [WIDTH-1:0] event_pending,
  output wire             wake_request,
  output wire             seq_trigger
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [15:0]      pin_function_config_reg;
  reg  [WIDTH-1:0] output_enable_reg;
  reg  [WIDTH-1:0] pull_resistor_enable_reg;
  reg  [WIDTH-1:0] input_path_enable_reg;
  reg  [WIDTH-1:0] input_level_reg;
  reg  [WIDTH-1:0] output_level_reg;
  reg  [WIDTH-1:0] output_level_next;
  reg  [15:0]      ev_cfg0_reg;
  reg  [15:0]      ev_cfg1_reg;
  reg  [WIDTH-1:0] ev_pend_reg;
  reg  [WIDTH-1:0] ev_pend_next;
  reg  [WIDTH-1:0] sequencer_pin_sync_reg;
  reg  [WIDTH-1:0] sync1_reg;
  reg  [WIDTH-1:0] sync2_reg;
  reg  [WIDTH-1:0] int_drv;
  reg  [WIDTH-1:0] out_mux;
  wire [WIDTH-1:0] ev_hit;
  wire             wr_hit;
  integer          i;

  // Two-bit function field of pin n; pin 7 field is bits 15:14
  function [1:0] fn_sel;
    input [15:0] cfg;
    input integer n;
    begin
      fn_sel = cfg[2*n +: 2];
    end
  endfunction

  // Three-bit event mode of pin n from the two config words
  function [2:0] ev_mode;
    input [15:0] c0;
    input [15:0] c1;
    input integer n;
    begin
      if (n < 4) begin
        ev_mode = c0[4*n +: 3];
      end else begin
        ev_mode = c1[4*(n-4) +: 3];
      end
    end
  endfunction

  function ev_en;
    input [15:0] c0;
    input [15:0] c1;
    input integer n;
    begin
      if (n < 4) begin
        ev_en = c0[4*n+3];
      end else begin
        ev_en = c1[4*(n-4)+3];
      end
    end
  endfunction

  assign wr_hit = reg_wr;

  ////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser and registered readback
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg       <= `EGP_RST_8;
      sync2_reg       <= `EGP_RST_8;
      input_level_reg <= `EGP_RST_8;
    end else begin
      sync1_reg       <= pin_in;
      sync2_reg       <= sync1_reg;
      input_level_reg <= sync2_reg & input_path_enable_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event detection
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : det
      egp_event_det u_det (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .level_in  (sync2_reg[g]),
        .enable    (ev_en(ev_cfg0_reg, ev_cfg1_reg, g)),
        .mode      (ev_mode(ev_cfg0_reg, ev_cfg1_reg, g)),
        .event_out (ev_hit[g])
      );
    end
  endgenerate

  // Set wins over a clear in the same cycle
  always @* begin
    ev_pend_next = ev_pend_reg;
    if (wr_hit && reg_addr == `EGP_OFS_EVCLR) begin
      ev_pend_next = ev_pend_reg & ~reg_wdata[WIDTH-1:0];
    end
    ev_pend_next = ev_pend_next | ev_hit;
  end

  assign event_pending = ev_pend_reg;
  assign wake_request  = |ev_pend_reg;
  assign seq_trigger   = |ev_hit;

  ////////////////////////////////////////////////////////////////////////
  // Output data with atomic set, clear and toggle
  always @* begin
    output_level_next = output_level_reg;
    if (wr_hit) begin
      case (reg_addr)
        `EGP_OFS_OUT:
          output_level_next = reg_wdata[WIDTH-1:0];
        `EGP_OFS_SET:
          output_level_next = output_level_reg | reg_wdata[WIDTH-1:0];
        `EGP_OFS_CLR:
          output_level_next = output_level_reg & ~reg_wdata[WIDTH-1:0];
        `EGP_OFS_TGL:
          output_level_next = output_level_reg ^ reg_wdata[WIDTH-1:0];
        default:
          output_level_next = output_level_reg;
      endcase
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_function_config_reg  <= `EGP_RST_16;
      output_enable_reg        <= `EGP_RST_8;
      pull_resistor_enable_reg <= `EGP_RST_8;
      input_path_enable_reg    <= `EGP_RST_8;
      output_level_reg         <= `EGP_RST_8;
      ev_cfg0_reg              <= `EGP_RST_16;
      ev_cfg1_reg              <= `EGP_RST_16;
      ev_pend_reg              <= `EGP_RST_8;
      sequencer_pin_sync_reg   <= `EGP_RST_8;
    end else begin
      output_level_reg <= output_level_next;
      ev_pend_reg      <= ev_pend_next;
      if (seq_sync_wr) begin
        sequencer_pin_sync_reg <= seq_sync_data;
      end
      if (wr_hit) begin
        case (reg_addr)
          `EGP_OFS_FUNC:   pin_function_config_reg <= reg_wdata;
          `EGP_OFS_OE:     output_enable_reg <= reg_wdata[WIDTH-1:0];
          `EGP_OFS_PULL:   pull_resistor_enable_reg <= reg_wdata[WIDTH-1:0];
          `EGP_OFS_INEN:   input_path_enable_reg <= reg_wdata[WIDTH-1:0];
          `EGP_OFS_EVCFG0: ev_cfg0_reg <= reg_wdata;
          `EGP_OFS_EVCFG1: ev_cfg1_reg <= reg_wdata;
          default:         ev_cfg0_reg <= ev_cfg0_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Function multiplexer
  always @* begin
    int_drv = `EGP_RST_8;
    int_drv[0] = interrupt_line_zero;
    int_drv[3] = interrupt_line_zero;
    int_drv[6] = interrupt_line_zero;
    int_drv[4] = interrupt_line_one;
    int_drv[7] = interrupt_line_one;
    for (i = 0; i < WIDTH; i = i + 1) begin
      case (fn_sel(pin_function_config_reg, i))
        `EGP_FN_INT:  out_mux[i] = int_drv[i];
        `EGP_FN_SYNC: out_mux[i] = sequencer_pin_sync_reg[i];
        default:      out_mux[i] = output_level_reg[i];
      endcase
    end
  end

  assign pin_out    = out_mux;
  assign pin_oe     = output_enable_reg;
  assign pull_up_on = pull_resistor_enable_reg & `EGP_PULL_MASK;

  ////////////////////////////////////////////////////////////////////////
  // Read mux, strobe registers read zero
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `EGP_RST_16;
    end else if (reg_rd) begin
      case (reg_addr)
        `EGP_OFS_FUNC:   reg_rdata <= pin_function_config_reg;
        `EGP_OFS_OE:     reg_rdata <= {8'h00, output_enable_reg};
        `EGP_OFS_PULL:   reg_rdata <= {8'h00, pull_resistor_enable_reg};
        `EGP_OFS_INEN:   reg_rdata <= {8'h00, input_path_enable_reg};
        `EGP_OFS_IN:     reg_rdata <= {8'h00, input_level_reg};
        `EGP_OFS_OUT:    reg_rdata <= {8'h00, output_level_reg};
        `EGP_OFS_EVCFG0: reg_rdata <= ev_cfg0_reg;
        `EGP_OFS_EVCFG1: reg_rdata <= ev_cfg1_reg;
        `EGP_OFS_EVPEND: reg_rdata <= {8'h00, ev_pend_reg};
        `EGP_OFS_SYNC:   reg_rdata <= {8'h00, sequencer_pin_sync_reg};
        default:         reg_rdata <= `EGP_RST_16;
      endcase
    end
  end

endmodule

//--- testbench/egp_pin_model.sv
// Purpose: External devices on the pins
// Assumes: Port drive wins, then external, then pull-up
// Notes:   A floating pin shows the inverse of the drive value
`timescale 1ns/100ps
module egp_pin_model (
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe,
  input  wire [7:0] pull_up_on,
  input  wire [7:0] ext_val,
  input  wire [7:0] ext_en,
  output wire [7:0] pin_lvl
);
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pull_up_on | ~pin_out));
endmodule

//--- testbench/egp_port_properties.sv
// Purpose: Port checks
// Assumes: Mirrors of function and input enable writes
// Notes:   Bound to egp_port
`timescale 1ns/100ps
module egp_port_properties (
  input wire        clk,
  input wire        sys_rst,
  input wire [5:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire [7:0]  pin_in,
  input wire [7:0]  pin_out,
  input wire [7:0]  pin_oe,
  input wire [7:0]  pull_up_on,
  input wire        interrupt_line_zero,
  input wire        seq_sync_wr,
  input wire [7:0]  seq_sync_data,
  input wire [7:0]  event_pending,
  input wire        wake_request
);
  reg  [15:0] fn_reg;
  reg  [7:0]  ien_reg;
  wire [7:0]  w  = reg_wdata[7:0];
  wire [7:0]  st = pin_out | w;
  wire [7:0]  cl = pin_out & ~w;
  wire [7:0]  tg = pin_out ^ w;
  wire [7:0]  pm = pin_in & ien_reg;
  wire [15:0] q  = {pin_in, ien_reg};
  wire        go = reg_wr && fn_reg == 16'h0000;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fn_reg  <= 16'h0000;
      ien_reg <= 8'h00;
    end else if (reg_wr && reg_addr == 6'h00) begin
      fn_reg <= reg_wdata;
    end else if (reg_wr && reg_addr == 6'h0c) begin
      ien_reg <= w;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_quiet; $stable(q)[*4]; endsequence
  sequence s_rd_in; reg_rd && reg_addr == 6'h10; endsequence
  property p_oe; reg_wr && reg_addr == 6'h04 |=> pin_oe == $past(w);
  endproperty
  property p_set; go && reg_addr == 6'h18 |=> pin_out == $past(st);
  endproperty
  property p_clr; go && reg_addr == 6'h1c |=> pin_out == $past(cl);
  endproperty
  property p_tgl; go && reg_addr == 6'h20 |=> pin_out == $past(tg);
  endproperty
  property p_rd0; reg_rd && reg_addr >= 6'h18 && reg_addr <= 6'h20
    |=> reg_rdata == 16'h0000; endproperty
  property p_pull; reg_wr && reg_addr == 6'h08
    |=> pull_up_on == ($past(w) & 8'hfb); endproperty
  property p_wake; wake_request == |event_pending; endproperty
  property p_in; s_quiet ##0 s_rd_in |=> reg_rdata[7:0] == $past(pm);
  endproperty
  property p_int; fn_reg[1:0] == 2'h1 |-> pin_out[0] == interrupt_line_zero;
  endproperty
  property p_sync; fn_reg == 16'haaaa && seq_sync_wr
    |=> pin_out == $past(seq_sync_data); endproperty
  a_oe: assert property (p_oe) else $error("oe");
  a_set: assert property (p_set) else $error("set");
  a_clr: assert property (p_clr) else $error("clr");
  a_tgl: assert property (p_tgl) else $error("tgl");
  a_rd0: assert property (p_rd0) else $error("rd0");
  a_pull: assert property (p_pull) else $error("pull");
  a_wake: assert property (p_wake) else $error("wake");
  a_in: assert property (p_in) else $error("in");
  a_int: assert property (p_int) else $error("int");
  a_sync: assert property (p_sync) else $error("sync");
endmodule
bind egp_port egp_port_properties chk_u (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_on(pull_up_on),
  .interrupt_line_zero(interrupt_line_zero), .seq_sync_wr(seq_sync_wr),
  .seq_sync_data(seq_sync_data), .event_pending(event_pending),
  .wake_request(wake_request));

//--- testbench/egp_port_tb.sv
// Purpose: Self-checking bench for the port
// Assumes: Inputs driven on falling edges
// Notes:   Read results checked by a monitor from a queue
`timescale 1ns/100ps
module egp_port_tb;
  reg         clk, sys_rst, reg_wr, reg_rd, seq_sync_wr, s;
  reg         interrupt_line_zero, interrupt_line_one, rd_seen;
  reg  [5:0]  reg_addr;
  reg  [15:0] reg_wdata, exq[$];
  reg  [7:0]  seq_sync_data, ext_val, ext_en, o, d, sd;
  wire [15:0] reg_rdata;
  wire [7:0]  pin_in, pin_out, pin_oe, pull_up_on, event_pending;
  wire        wake_request, seq_trigger;
  integer     num_errors, compares, seed, i, m;
  egp_port #(.WIDTH(8)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_on(pull_up_on),
    .interrupt_line_zero(interrupt_line_zero),
    .interrupt_line_one(interrupt_line_one), .seq_sync_wr(seq_sync_wr),
    .seq_sync_data(seq_sync_data), .event_pending(event_pending),
    .wake_request(wake_request), .seq_trigger(seq_trigger));
  egp_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_on(pull_up_on), .ext_val(ext_val), .ext_en(ext_en),
    .pin_lvl(pin_in));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (num_errors == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task wr(input [5:0] a, input [15:0] v);
    begin
      reg_wr = 1'b1;
      reg_rd = 1'b0;
      reg_addr = a;
      reg_wdata = v;
      @(negedge clk);
    end
  endtask
  task rd(input [5:0] a, input [15:0] e);
    begin
      reg_rd = 1'b1;
      reg_wr = 1'b0;
      reg_addr = a;
      exq.push_back(e);
      @(negedge clk);
    end
  endtask
  task idle;
    begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      @(negedge clk);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors = num_errors + 1;
    test_done;
  end
  always @(posedge clk) rd_seen <= reg_rd;
  // Read data settles one edge after the read
  always @(negedge clk) begin
    if (rd_seen)
      chk(reg_rdata, exq.pop_front());
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 22'h0};
    {interrupt_line_zero, interrupt_line_one, seq_sync_wr} = 3'h0;
    {seq_sync_data, ext_val, ext_en} = 24'h0;
    {num_errors, compares, seed} = {32'd0, 32'd0, 32'd78};
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    for (i = 0; i < 16; i = i + 1)
      rd({i[3:0], 2'b00}, 16'h0000);
    o = $random(seed);
    wr(6'h14, {8'h00, o});
    wr(6'h04, 16'h00ff);
    for (i = 0; i < 12; i = i + 1) begin
      m = i % 3;
      d = $random(seed);
      wr(m == 0 ? 6'h18 : m == 1 ? 6'h1c : 6'h20, {8'h00, d});
      o = m == 0 ? o | d : m == 1 ? o & ~d : o ^ d;
      rd(6'h14, {8'h00, o});
      chk(pin_out, o);
    end
    ext_en = 8'hff;
    ext_val = $random(seed);
    wr(6'h04, 16'h0000);
    wr(6'h0c, 16'h000f);
    repeat (5) idle;
    chk(pin_oe, 8'h00);
    rd(6'h14, {8'h00, o});
    rd(6'h10, {12'h000, ext_val[3:0]});
    wr(6'h08, 16'hffff);
    chk(pull_up_on, 8'hfb);
    for (m = 0; m < 5; m = m + 1) begin
      s = (m == 1 || m == 4);
      ext_val[0] = s;
      repeat (5) idle;
      wr(6'h24, {12'h000, 1'b1, m[2:0]});
      repeat (2) idle;
      wr(6'h2c, 16'h00ff);
      rd(6'h30, 16'h0000);
      ext_val[0] = ~s;
      repeat (5) idle;
      rd(6'h30, 16'h0001);
      chk({15'h0000, wake_request}, 16'h0001);
      chk({8'h00, event_pending}, 16'h0001);
      chk({15'h0000, seq_trigger}, m > 2 ? 16'h0001 : 16'h0000);
    end
    wr(6'h04, 16'h00ff);
    wr(6'h00, 16'h0101);
    for (i = 0; i < 8; i = i + 1) begin
      {interrupt_line_one, interrupt_line_zero} = i[1:0];
      idle;
      chk({pin_out[4], pin_out[0]}, i[1:0]);
    end
    for (i = 0; i < 2; i = i + 1) begin
      wr(6'h00, i ? 16'h0002 : 16'haaaa);
      sd = $random(seed);
      seq_sync_data = sd;
      seq_sync_wr = 1'b1;
      idle;
      seq_sync_wr = 1'b0;
      chk(pin_out, i ? {o[7:1], sd[0]} : sd);
    end
    repeat (2) idle;
    chk(exq.size(), 16'h0000);
    test_done;
  end
endmodule
